// file: rtl/pra_defines.vh
/*
 * Constants for the page request auto-responder: field widths,
 * response codes, software command types and controller states.
 * Assumes inclusion by bare name from the rtl folder.
 */
`ifndef PRA_DEFINES_VH
`define PRA_DEFINES_VH

// field widths
`define PRA_SID_W 32
`define PRA_GRP_W 9
`define PRA_PASID_W 20
`define PRA_CODE_W 4

// group response codes
`define PRA_CODE_SUCCESS 4'h0
`define PRA_CODE_INVALID 4'h1
`define PRA_CODE_FAILURE 4'hf

// software response command types
`define PRA_CMD_SUCCESS 2'h0
`define PRA_CMD_INVALID 2'h1
`define PRA_CMD_FAILURE 2'h2

// controller states
`define PRA_ST_IDLE 2'h0
`define PRA_ST_WRITE 2'h1
`define PRA_ST_WAIT 2'h2

`endif

// file: rtl/pra_responder.v
/*
 * Page request auto-responder: takes page requests and stop markers,
 * writes them to the page request queue or discards them with an
 * automatic group response, and forwards software response commands.
 * Assumes every input comes from logic on CLK (no synchronisers),
 * a stream table lookup result valid with the message, and one
 * queue write outstanding at a time.
 * Limitations: one response slot, so a slow response link throttles
 * message intake; a write withdrawn in the cycle that the memory side
 * accepts it still counts as withdrawn; overflow clears on a level
 * acknowledge rather than a flag toggle.
 * Stop markers that pass every check are written like page requests.
 */
`include "pra_defines.vh"
`default_nettype none

// Function
// RQ1: any external abort on queue access raises the queue abort error.
// RQ2: synchronous abort on entry write answers that request with 0b1111.
// RQ3: asynchronous abort on entry write sends no automatic response.
// RQ4: aborts from reads inside queue bounds count like write aborts.
// RQ5: requests from Secure streams are discarded and answered with 0b1111.
// RQ6: no queue writes while abort error is set or queue disabled.
// RQ7: disabled or abort state: every request discarded, answered 0b1111.
// RQ8: ATS check and per-stream ATS enable do not affect requests.
// RQ9: stop markers never produce any response.
// RQ10: automatic response keeps the stream identifier of its request.
// RQ11: automatic response keeps the group index of its request.
// RQ12: disabled or abort responses never carry a PASID prefix.
// RQ13: PASID only on overflow, substreams, pasid bits, non-failure, had PASID.
// RQ14: a response PASID equals the request PASID.
// RQ15: invalid-request command goes out with code 0b0001.
// RQ16: response-failure command goes out with code 0b1111.
// RQ17: overflow response succeeds without PASID, always-PASID, or entry ok.
// RQ18: overflow response fails on PASID, no always-PASID, no valid entry.
// RQ19: success is encoded as 0b0000.
// RQ20: during overflow, non-last requests are dropped without response.
// RQ21: a pending response is held until the outbound link takes it.
module pra_responder (
    input wire CLK,
    input wire SRST,
    input wire UNIT_ENABLE,
    input wire QUEUE_ENABLE,
    input wire SUBSTREAMS_SUPPORTED,
    input wire ALWAYS_PASID_ON_RESPONSE,
    input wire QUEUE_FULL,
    input wire OVERFLOW_ACK,
    input wire ABORT_CLEAR,
    input wire MSG_VALID,
    output reg MSG_READY,
    input wire MSG_IS_STOP,
    input wire MSG_SECURE,
    input wire MSG_LAST,
    input wire MSG_HAS_PASID,
    input wire [`PRA_PASID_W-1:0] MSG_PASID,
    input wire [`PRA_SID_W-1:0] MSG_SID,
    input wire [`PRA_GRP_W-1:0] MSG_GROUP,
    input wire STREAM_ENTRY_VALID,
    input wire STREAM_ENTRY_PASID_ON_RESPONSE,
    output reg WR_VALID,
    input wire WR_READY,
    output reg WR_IS_STOP,
    output reg WR_LAST,
    output reg WR_HAS_PASID,
    output reg [`PRA_PASID_W-1:0] WR_PASID,
    output reg [`PRA_SID_W-1:0] WR_SID,
    output reg [`PRA_GRP_W-1:0] WR_GROUP,
    input wire WR_DONE,
    input wire WR_ABORT_SYNC,
    input wire WR_ABORT_ASYNC,
    input wire RD_ABORT,
    input wire CMD_VALID,
    output reg CMD_READY,
    input wire [1:0] CMD_TYPE,
    input wire CMD_HAS_PASID,
    input wire [`PRA_PASID_W-1:0] CMD_PASID,
    input wire [`PRA_SID_W-1:0] CMD_SID,
    input wire [`PRA_GRP_W-1:0] CMD_GROUP,
    output reg RSP_VALID,
    input wire RSP_READY,
    output reg [`PRA_CODE_W-1:0] RSP_CODE,
    output reg RSP_HAS_PASID,
    output reg [`PRA_PASID_W-1:0] RSP_PASID,
    output reg [`PRA_SID_W-1:0] RSP_SID,
    output reg [`PRA_GRP_W-1:0] RSP_GROUP,
    output reg ABORT_ERROR,
    output reg OVERFLOW
);

////////////////////////////////////////////////////////////////////////
// helpers

// software command type to response code
// the reserved type answers success
function [`PRA_CODE_W-1:0] cmd_code;
    input [1:0] kind;
    begin
        case (kind)
            `PRA_CMD_INVALID: cmd_code = `PRA_CODE_INVALID; // RQ15
            `PRA_CMD_FAILURE: cmd_code = `PRA_CODE_FAILURE; // RQ16
            default: cmd_code = `PRA_CODE_SUCCESS; // RQ19
        endcase
    end
endfunction

// overflow response code
function [`PRA_CODE_W-1:0] ovf_code;
    input has_pasid;
    input always_pasid;
    input entry_valid;
    begin
        if (!has_pasid || always_pasid || entry_valid) begin
            ovf_code = `PRA_CODE_SUCCESS; // RQ17
        end else begin
            ovf_code = `PRA_CODE_FAILURE; // RQ18
        end
    end
endfunction

// queue effectively closed to new entries
function queue_shut;
    input abort;
    input unit_on;
    input queue_en;
    begin
        queue_shut = abort || !(unit_on && queue_en); // RQ6
    end
endfunction

// pasid prefix on an overflow response
function ovf_pasid;
    input substreams;
    input always_pasid;
    input entry_pasid;
    input [`PRA_CODE_W-1:0] code;
    input has_pasid;
    begin
        ovf_pasid = substreams && (always_pasid || entry_pasid) &&
            code != `PRA_CODE_FAILURE && has_pasid; // RQ13
    end
endfunction

////////////////////////////////////////////////////////////////////////
// state

reg [1:0] state;
reg [1:0] next_state;
reg next_msg_ready;
reg next_cmd_ready;
reg next_wr_valid;
reg next_rsp_valid;
reg next_abort;
reg next_overflow;
// decision results for the current cycle
reg set_abort;
reg set_overflow;
reg msg_fire;
reg cmd_take;
reg queue_on;
reg free_idle;
reg shut;
// load request for the single response slot
reg ld;
reg [`PRA_CODE_W-1:0] ld_code;
reg ld_has_pasid;
reg [`PRA_PASID_W-1:0] ld_pasid;
reg [`PRA_SID_W-1:0] ld_sid;
reg [`PRA_GRP_W-1:0] ld_group;
reg [`PRA_CODE_W-1:0] oc;

////////////////////////////////////////////////////////////////////////
// next-state logic

always @* begin
    next_state = state;
    next_wr_valid = WR_VALID;
    next_rsp_valid = RSP_VALID;
    set_abort = 1'b0;
    set_overflow = 1'b0;
    ld = 1'b0;
    ld_code = `PRA_CODE_FAILURE;
    ld_has_pasid = 1'b0;
    ld_pasid = MSG_PASID;
    ld_sid = MSG_SID;
    ld_group = MSG_GROUP;
    msg_fire = MSG_VALID && MSG_READY;
    cmd_take = CMD_VALID && CMD_READY;
    // ats settings have no input here at all
    queue_on = QUEUE_ENABLE && UNIT_ENABLE; // RQ8
    shut = queue_shut(ABORT_ERROR, UNIT_ENABLE, QUEUE_ENABLE);
    // overflow code is worked out every cycle, used only on overflow
    oc = ovf_code(MSG_HAS_PASID, ALWAYS_PASID_ON_RESPONSE,
        STREAM_ENTRY_VALID);

    if (RD_ABORT && queue_on) begin
        set_abort = 1'b1; // RQ4
    end
    // any write abort counts, even one for a withdrawn write
    if (WR_DONE && (WR_ABORT_SYNC || WR_ABORT_ASYNC)) begin
        set_abort = 1'b1; // RQ1
    end
    // hold the response until the link takes it
    if (RSP_VALID && RSP_READY) begin
        next_rsp_valid = 1'b0; // RQ21
    end

    case (state)
        `PRA_ST_IDLE: begin
            // refusal beats overflow, overflow beats a queue write
            if (msg_fire) begin
                if (MSG_SECURE || shut) begin
                    if (!MSG_IS_STOP) begin
                        ld = 1'b1; // RQ5
                        ld_code = `PRA_CODE_FAILURE; // RQ7
                        ld_has_pasid = 1'b0; // RQ12
                    end
                end else if (OVERFLOW || QUEUE_FULL) begin
                    set_overflow = 1'b1;
                    if (!MSG_IS_STOP && MSG_LAST) begin // RQ20
                        ld = 1'b1;
                        ld_code = oc;
                        ld_has_pasid = ovf_pasid(SUBSTREAMS_SUPPORTED,
                            ALWAYS_PASID_ON_RESPONSE,
                            STREAM_ENTRY_PASID_ON_RESPONSE, oc,
                            MSG_HAS_PASID); // RQ13
                    end
                end else begin
                    next_state = `PRA_ST_WRITE;
                    next_wr_valid = 1'b1;
                end
            end else if (cmd_take) begin
                // software commands skip every queue check
                ld = 1'b1;
                ld_code = cmd_code(CMD_TYPE);
                ld_has_pasid = CMD_HAS_PASID;
                ld_pasid = CMD_PASID;
                ld_sid = CMD_SID;
                ld_group = CMD_GROUP;
            end
        end
        `PRA_ST_WRITE: begin
            // withdraw an unissued write once the queue shuts
            if (shut) begin
                next_wr_valid = 1'b0; // RQ6
                next_state = `PRA_ST_IDLE;
                ld = !WR_IS_STOP; // RQ9
                ld_pasid = WR_PASID;
                ld_sid = WR_SID;
                ld_group = WR_GROUP;
            end else if (WR_READY) begin
                next_wr_valid = 1'b0;
                next_state = `PRA_ST_WAIT;
            end
        end
        `PRA_ST_WAIT: begin
            if (WR_DONE) begin
                next_state = `PRA_ST_IDLE;
                // both abort kinds together count as asynchronous
                // async abort leaves no response behind
                if (WR_ABORT_SYNC && !WR_ABORT_ASYNC) begin // RQ3
                    ld = !WR_IS_STOP; // RQ2
                    ld_pasid = WR_PASID;
                    ld_sid = WR_SID;
                    ld_group = WR_GROUP;
                end
            end
        end
        default: begin
            next_state = `PRA_ST_IDLE;
            next_wr_valid = 1'b0;
        end
    endcase

    // a load always fills the slot; the ready rule keeps it empty first
    if (ld) begin
        next_rsp_valid = 1'b1;
    end
    // set wins over clear on both flags
    next_abort = set_abort || (ABORT_ERROR && !ABORT_CLEAR);
    next_overflow = set_overflow || (OVERFLOW && !OVERFLOW_ACK);

    // a gap cycle after each take keeps the slot single-loaded
    free_idle = next_state == `PRA_ST_IDLE && !next_rsp_valid &&
        !msg_fire && !cmd_take;
    // commands win the slot over messages when both wait
    next_cmd_ready = free_idle && CMD_VALID;
    next_msg_ready = free_idle && !next_cmd_ready;
end

////////////////////////////////////////////////////////////////////////
// registers

always @(posedge CLK) begin
    if (SRST) begin
        state <= `PRA_ST_IDLE;
        MSG_READY <= 1'b0;
        CMD_READY <= 1'b0;
        WR_VALID <= 1'b0;
        WR_IS_STOP <= 1'b0;
        WR_LAST <= 1'b0;
        WR_HAS_PASID <= 1'b0;
        WR_PASID <= {`PRA_PASID_W{1'b0}};
        WR_SID <= {`PRA_SID_W{1'b0}};
        WR_GROUP <= {`PRA_GRP_W{1'b0}};
        RSP_VALID <= 1'b0;
        RSP_CODE <= `PRA_CODE_SUCCESS;
        RSP_HAS_PASID <= 1'b0;
        RSP_PASID <= {`PRA_PASID_W{1'b0}};
        RSP_SID <= {`PRA_SID_W{1'b0}};
        RSP_GROUP <= {`PRA_GRP_W{1'b0}};
        ABORT_ERROR <= 1'b0;
        OVERFLOW <= 1'b0;
    end else begin
        state <= next_state;
        MSG_READY <= next_msg_ready;
        CMD_READY <= next_cmd_ready;
        WR_VALID <= next_wr_valid;
        RSP_VALID <= next_rsp_valid;
        ABORT_ERROR <= next_abort;
        OVERFLOW <= next_overflow;
        // the write record doubles as the held request
        if (msg_fire) begin
            WR_IS_STOP <= MSG_IS_STOP;
            WR_LAST <= MSG_LAST;
            WR_HAS_PASID <= MSG_HAS_PASID;
            WR_PASID <= MSG_PASID;
            WR_SID <= MSG_SID;
            WR_GROUP <= MSG_GROUP;
        end
        // response fields move only on a load, so they stand while valid
        if (ld) begin
            RSP_CODE <= ld_code;
            RSP_HAS_PASID <= ld_has_pasid;
            RSP_PASID <= ld_pasid; // RQ14
            RSP_SID <= ld_sid; // RQ10
            RSP_GROUP <= ld_group; // RQ11
        end
    end
end

endmodule // pra_responder

`default_nettype wire

// file: bench/pra_asserts.sv
/* pra_asserts: timing rules at the ports of pra_responder.
   assumes it is bound into pra_responder, everything on CLK. */
`default_nettype none
module pra_asserts (
    input wire logic CLK, SRST, UNIT_ENABLE, QUEUE_ENABLE, ABORT_ERROR,
    input wire logic OVERFLOW, MSG_VALID, MSG_READY, MSG_IS_STOP, MSG_SECURE,
    input wire logic MSG_LAST, WR_VALID, WR_DONE, WR_ABORT_SYNC,
    input wire logic WR_ABORT_ASYNC, WR_IS_STOP,
    input wire logic CMD_VALID, CMD_READY, RSP_VALID, RSP_READY, RSP_HAS_PASID,
    input wire logic [31:0] MSG_SID, RSP_SID,
    input wire logic [8:0] MSG_GROUP, RSP_GROUP,
    input wire logic [1:0] CMD_TYPE,
    input wire logic [3:0] RSP_CODE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    wire tk = MSG_VALID & MSG_READY & !MSG_IS_STOP;
    wire off = !UNIT_ENABLE | !QUEUE_ENABLE | ABORT_ERROR;
    wire ct = CMD_VALID & CMD_READY;
    ////////////////////////////////////////
    fail_auto_a: assert property (tk & (MSG_SECURE | off) |=>
        RSP_VALID && RSP_CODE == 4'hf && !RSP_HAS_PASID)
        else $error("bad failure response");
    stop_silent_a: assert property (MSG_VALID & MSG_READY
        & MSG_IS_STOP & !ct |=> !RSP_VALID) else $error("stop answered");
    no_write_a: assert property (MSG_VALID & MSG_READY & off
        |=> !WR_VALID) else $error("write while queue off");
    echo_ids_a: assert property (tk & MSG_SECURE |=>
        RSP_SID == $past(MSG_SID) && RSP_GROUP == $past(MSG_GROUP))
        else $error("response ids differ");
    rsp_hold_a: assert property (RSP_VALID & !RSP_READY |=>
        RSP_VALID && $stable(RSP_CODE) && $stable(RSP_SID))
        else $error("response dropped");
    cmd_code_a: assert property (ct |=> RSP_VALID && RSP_CODE ==
        ($past(CMD_TYPE) == 2'h1 ? 4'h1 : $past(CMD_TYPE) == 2'h2 ? 4'hf
        : 4'h0)) else $error("command code wrong");
    sync_abort_a: assert property (WR_DONE & WR_ABORT_SYNC
        & !WR_ABORT_ASYNC & !WR_IS_STOP |=> ABORT_ERROR && RSP_VALID
        && RSP_CODE == 4'hf)
        else $error("sync abort not answered");
    async_quiet_a: assert property (WR_DONE & WR_ABORT_ASYNC
        |=> ABORT_ERROR && !RSP_VALID) else $error("async abort answered");
    ovf_drop_a: assert property (tk & !MSG_SECURE & !off & OVERFLOW
        & !MSG_LAST |=> !RSP_VALID && !WR_VALID)
        else $error("non-last not dropped");
endmodule // pra_asserts
bind pra_responder pra_asserts i_chk (.*);
`default_nettype wire

// file: bench/pra_mem_model.sv
/* pra_mem_model: memory side of the queue write port.
   assumes SLOW sets the accept delay, MODE 1 sync abort, 2 async. */
`default_nettype none
module pra_mem_model (
    input wire logic CLK, SRST, WR_VALID,
    input wire logic [1:0] MODE, SLOW,
    output logic WR_READY, WR_DONE, WR_ABORT_SYNC, WR_ABORT_ASYNC
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt;
    ////////////////////////////////////////
    always @(posedge CLK) begin
        WR_READY <= 1'b0;
        WR_DONE <= 1'b0;
        WR_ABORT_SYNC <= 1'b0;
        WR_ABORT_ASYNC <= 1'b0;
        cnt <= 2'h0;
        if (!SRST) begin
            // exactly one completion for each accepted write
            if (WR_READY) begin
                WR_DONE <= 1'b1;
                WR_ABORT_SYNC <= MODE == 2'h1;
                WR_ABORT_ASYNC <= MODE == 2'h2;
            end else if (WR_VALID && cnt >= SLOW) begin
                WR_READY <= 1'b1;
            end else if (WR_VALID) begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // pra_mem_model
`default_nettype wire

// file: bench/pra_responder_tb.sv
/* pra_responder_tb: random and corner traffic on the responder.
   assumes the checker is bound and the memory model is on WR_*. */
`default_nettype none
module pra_responder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK, SRST, UNIT_ENABLE, QUEUE_ENABLE, SUBSTREAMS_SUPPORTED;
    logic ALWAYS_PASID_ON_RESPONSE, QUEUE_FULL, OVERFLOW_ACK, ABORT_CLEAR;
    logic MSG_VALID, MSG_READY, MSG_IS_STOP, MSG_SECURE, MSG_LAST;
    logic MSG_HAS_PASID, STREAM_ENTRY_VALID, STREAM_ENTRY_PASID_ON_RESPONSE;
    logic WR_VALID, WR_READY, WR_IS_STOP, WR_LAST, WR_HAS_PASID, WR_DONE;
    logic WR_ABORT_SYNC, WR_ABORT_ASYNC, RD_ABORT, CMD_VALID, CMD_READY;
    logic CMD_HAS_PASID, RSP_VALID, RSP_READY, RSP_HAS_PASID, ABORT_ERROR;
    logic OVERFLOW, ov, ab;
    logic [1:0] CMD_TYPE, MODE, SLOW;
    logic [3:0] RSP_CODE;
    logic [19:0] MSG_PASID, WR_PASID, CMD_PASID, RSP_PASID;
    logic [31:0] MSG_SID, WR_SID, CMD_SID, RSP_SID, r, q;
    logic [8:0] MSG_GROUP, WR_GROUP, CMD_GROUP, RSP_GROUP;
    int errors, tests_run;
    pra_responder i_dut (.*);
    pra_mem_model i_mem (.*);
    ////////////////////////////////////////
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // f is {stop, secure, last, pasid}; result {write, resp, pasid, code}
    function automatic logic [6:0] want(input logic [3:0] f);
        logic ok;
        ok = !f[0] | ALWAYS_PASID_ON_RESPONSE | STREAM_ENTRY_VALID;
        if (f[2] | !UNIT_ENABLE | !QUEUE_ENABLE | ab)
            return f[3] ? 7'h00 : 7'h2f;
        if (ov | QUEUE_FULL)
            return (f[3] | !f[1]) ? 7'h00 : {2'b01, SUBSTREAMS_SUPPORTED & ok
                & f[0] & (ALWAYS_PASID_ON_RESPONSE
                | STREAM_ENTRY_PASID_ON_RESPONSE), ok ? 4'h0 : 4'hf};
        return 7'h40;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (e !== g) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic await(ref logic s);
        int n;
        n = 0;
        do begin @(posedge CLK); #1; n++; end while (s !== 1'b1 && n < 60);
        if (s !== 1'b1) begin
            errors++;
            $display("mismatch await expected 1 seen %b", s);
        end
    endtask
    task automatic msg(input logic [3:0] f);
        logic [6:0] e;
        @(posedge CLK);
        {MSG_IS_STOP, MSG_SECURE, MSG_LAST, MSG_HAS_PASID} <= f;
        {MSG_SID, MSG_GROUP, MSG_PASID} <= {r, r[8:0], r[31:12]};
        MSG_VALID <= 1'b1;
        @(posedge CLK);
        MSG_VALID <= 1'b0;
        #1 e = want(f);
        chk("write", e[6], WR_VALID);
        chk("resp", e[5], RSP_VALID);
        if (e[6]) chk("wsid", MSG_SID, WR_SID);
        if (e[6]) chk("wrec", {f[3], f[1], f[0], MSG_PASID, MSG_GROUP},
            {WR_IS_STOP, WR_LAST, WR_HAS_PASID, WR_PASID, WR_GROUP});
        if (e[5]) begin
            chk("code", e[3:0], RSP_CODE);
            chk("pasid", e[4], RSP_HAS_PASID);
            chk("sid", MSG_SID, RSP_SID);
            chk("group", MSG_GROUP, RSP_GROUP);
            if (e[4]) chk("pval", MSG_PASID, RSP_PASID);
        end
        ov = ov | QUEUE_FULL & !f[2] & UNIT_ENABLE & QUEUE_ENABLE & !ab;
        chk("ovf", ov, OVERFLOW);
    endtask
    task automatic cmd(input logic [1:0] t, input logic [3:0] c);
        @(posedge CLK);
        {CMD_TYPE, CMD_HAS_PASID, CMD_SID, CMD_GROUP, CMD_PASID} <=
            {t, t[0], r, r[8:0], r[19:0]};
        CMD_VALID <= 1'b1;
        await(CMD_READY);
        @(posedge CLK);
        CMD_VALID <= 1'b0;
        #1 chk("cmd", c, RSP_CODE);
        chk("cvalid", 1'b1, RSP_VALID);
        chk("csid", CMD_SID, RSP_SID);
        chk("crec", {CMD_HAS_PASID, CMD_PASID, CMD_GROUP},
            {RSP_HAS_PASID, RSP_PASID, RSP_GROUP});
    endtask
    task automatic results;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        q <= SRST ? 32'h947613df : nx(q);
        RSP_READY <= q[3] | q[7]; // random stalls on the response link
    end
    initial begin
        #400000 errors++;
        results;
    end
    initial begin
        {UNIT_ENABLE, QUEUE_ENABLE, SUBSTREAMS_SUPPORTED, QUEUE_FULL} = '0;
        {ALWAYS_PASID_ON_RESPONSE, OVERFLOW_ACK, ABORT_CLEAR, MSG_VALID} = '0;
        {MSG_IS_STOP, MSG_SECURE, MSG_LAST, MSG_HAS_PASID, MSG_PASID} = '0;
        {MSG_SID, MSG_GROUP, STREAM_ENTRY_VALID, RD_ABORT, CMD_VALID} = '0;
        {STREAM_ENTRY_PASID_ON_RESPONSE, CMD_TYPE, CMD_HAS_PASID} = '0;
        {CMD_PASID, CMD_SID, CMD_GROUP, MODE, SLOW} = '0;
        {SRST, r, ov, ab, errors, tests_run} = {1'b1, 32'h947613df, 66'h0};
        repeat (6) @(posedge CLK);
        SRST <= 1'b0;
        for (int i = 0; i < 80; i++) begin
            await(MSG_READY);
            r = nx(r);
            @(posedge CLK);
            {UNIT_ENABLE, QUEUE_ENABLE, QUEUE_FULL} <= {|r[2:0], |r[5:3],
                r[6] & r[7]};
            {SUBSTREAMS_SUPPORTED, ALWAYS_PASID_ON_RESPONSE, STREAM_ENTRY_VALID,
                STREAM_ENTRY_PASID_ON_RESPONSE, SLOW} <= r[13:8];
            msg({r[16] & r[17], r[18] & r[19] & r[20], r[21] | r[22], r[23]});
            if (r[25]) begin
                @(posedge CLK) OVERFLOW_ACK <= 1'b1;
                @(posedge CLK) OVERFLOW_ACK <= 1'b0;
                ov = 1'b0;
            end
        end
        // write aborts: sync answered, request refused, then async silent and read abort
        await(MSG_READY);
        @(posedge CLK) {UNIT_ENABLE, QUEUE_ENABLE, QUEUE_FULL, MODE,
            OVERFLOW_ACK} <= 6'h33;
        ov = 1'b0;
        msg(4'h2);
        @(posedge CLK) OVERFLOW_ACK <= 1'b0;
        await(RSP_VALID);
        chk("abcode", 4'hf, RSP_CODE);
        chk("aberr", 1'b1, ABORT_ERROR);
        ab = 1'b1;
        await(MSG_READY);
        msg(4'h3);
        for (int k = 0; k < 2; k++) begin
            await(MSG_READY);
            @(posedge CLK) {ABORT_CLEAR, MODE} <= 3'h6;
            @(posedge CLK) ABORT_CLEAR <= 1'b0;
            ab = 1'b0;
            if (k == 0) msg(4'h2);
            if (k == 1) @(posedge CLK) RD_ABORT <= 1'b1;
            if (k == 1) @(posedge CLK) RD_ABORT <= 1'b0;
            await(MSG_READY);
            chk("aerr", 1'b1, ABORT_ERROR);
            chk("quiet", 1'b0, RSP_VALID);
        end
        for (int t = 0; t < 4; t++)
            cmd(t[1:0], t == 1 ? 4'h1 : t == 2 ? 4'hf : 4'h0);
        results;
    end
endmodule // pra_responder_tb
`default_nettype wire
